// >>> rtl/pssc_pkg.sv
// package of constants and types for the power state supply configuration block
package pssc_pkg;

	// register byte offsets
	localparam logic [7:0] PSSC_AWAKE_OFS   = 8'h18;
	localparam logic [7:0] PSSC_SLEEP1_OFS  = 8'h1C;
	localparam logic [7:0] PSSC_SLEEP2_OFS  = 8'h20;
	localparam logic [7:0] PSSC_STATUS_OFS  = 8'h24;
	localparam logic [7:0] PSSC_CONTROL_OFS = 8'h40;

	// field positions
	localparam int PSSC_DWELL_LSB   = 16;
	localparam int PSSC_DWELL_MSB   = 20;
	localparam int PSSC_TILE_OFF    = 14;
	localparam int PSSC_ANA_MODE    = 9;
	localparam int PSSC_CORE_MODE   = 8;
	localparam int PSSC_IO_EN       = 5;
	localparam int PSSC_PLL_EN      = 4;
	localparam int PSSC_ANA_EN      = 1;
	localparam int PSSC_CORE_EN     = 0;
	localparam int PSSC_STATE_LSB   = 16;
	localparam int PSSC_SLEEP_GO    = 0;

	// writable bit masks; bit 1 and reserved bits stay out
	localparam logic [31:0] PSSC_AWAKE_WMASK = 32'h0000_4331;
	localparam logic [31:0] PSSC_SLEEP_WMASK = 32'h001F_4331;

	// reset values
	localparam logic [31:0] PSSC_AWAKE_RST  = 32'h0000_0033;
	localparam logic [31:0] PSSC_SLEEP1_RST = 32'h0010_0022;
	localparam logic [31:0] PSSC_SLEEP2_RST = 32'h0010_0002;
	// fixed supply settings of the states that have no configuration register
	localparam logic [31:0] PSSC_ASLEEP_CFG = 32'h0000_4002;
	localparam logic [31:0] PSSC_WAKE1_CFG  = 32'h0000_4022;
	localparam logic [31:0] PSSC_WAKE2_CFG  = 32'h0000_4033;

	// axi response codes
	localparam logic [1:0] PSSC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PSSC_RESP_SLVERR = 2'h2;

	// state codes reported in status
	localparam logic [2:0] PSSC_CODE_RESET  = 3'h0;
	localparam logic [2:0] PSSC_CODE_ASLEEP = 3'h1;
	localparam logic [2:0] PSSC_CODE_WAKE1  = 3'h2;
	localparam logic [2:0] PSSC_CODE_WAKE2  = 3'h3;
	localparam logic [2:0] PSSC_CODE_WAIT   = 3'h4;
	localparam logic [2:0] PSSC_CODE_AWAKE  = 3'h5;
	localparam logic [2:0] PSSC_CODE_SLEEP1 = 3'h6;
	localparam logic [2:0] PSSC_CODE_SLEEP2 = 3'h7;

	// sequencer states, one-hot
	typedef enum logic [7:0] {
		PSSC_ST_RESET  = 8'h01,
		PSSC_ST_ASLEEP = 8'h02,
		PSSC_ST_WAKE1  = 8'h04,
		PSSC_ST_WAKE2  = 8'h08,
		PSSC_ST_WAIT   = 8'h10,
		PSSC_ST_AWAKE  = 8'h20,
		PSSC_ST_SLEEP1 = 8'h40,
		PSSC_ST_SLEEP2 = 8'h80
	} pssc_state_e;

	// supply controls driven to the regulators
	typedef struct packed {
		logic tile_clk_off;
		logic analogue_pfm;
		logic core_pfm;
		logic io_supply_output_en;
		logic pll_supply_regulator_en;
		logic analogue_converter_en;
		logic core_converter_en;
	} pssc_supply_s;

endpackage : pssc_pkg

// >>> rtl/pssc_top.sv
// power state sequencer with supply configuration registers for the awake and both sleep states on axi4-lite
`timescale 1ns/1ps
`default_nettype none
module pssc_top
	import pssc_pkg::*;
#(
	parameter logic [4:0] DWELL_RESET = 5'h10 // dwell log2 after reset; lower it to shorten simulation
)
(
	input  wire logic         clk,           // 125 MHz controller clock
	input  wire logic         rst_b,         // asynchronous reset, active low
	input  wire logic [7:0]   s_axi_awaddr,  // write address
	input  wire logic         s_axi_awvalid, // write address valid
	output logic              s_axi_awready, // write address ready
	input  wire logic [31:0]  s_axi_wdata,   // write data
	input  wire logic [3:0]   s_axi_wstrb,   // write byte strobes
	input  wire logic         s_axi_wvalid,  // write data valid
	output logic              s_axi_wready,  // write data ready
	output logic [1:0]        s_axi_bresp,   // write response
	output logic              s_axi_bvalid,  // write response valid
	input  wire logic         s_axi_bready,  // write response ready
	input  wire logic [7:0]   s_axi_araddr,  // read address
	input  wire logic         s_axi_arvalid, // read address valid
	output logic              s_axi_arready, // read address ready
	output logic [31:0]       s_axi_rdata,   // read data
	output logic [1:0]        s_axi_rresp,   // read response
	output logic              s_axi_rvalid,  // read data valid
	input  wire logic         s_axi_rready,  // read data ready
	input  wire logic         wake_request,  // asynchronous wake pin, high wakes from asleep
	output pssc_supply_s      supply_ctrl,   // supply and clock controls, registered
	output logic [2:0]        state_code     // current sequencer state code, registered
);

	// configuration storage: entry 0 awake, 1 first sleep, 2 second sleep
	logic [31:0]  cfg_reg [3];
	logic [31:0]  cfg_wmask [3];
	logic [31:0]  cfg_rst [3];
	logic [7:0]   cfg_ofs [3];

	assign cfg_wmask[0] = PSSC_AWAKE_WMASK;
	assign cfg_wmask[1] = PSSC_SLEEP_WMASK;
	assign cfg_wmask[2] = PSSC_SLEEP_WMASK;
	assign cfg_ofs[0]   = PSSC_AWAKE_OFS;
	assign cfg_ofs[1]   = PSSC_SLEEP1_OFS;
	assign cfg_ofs[2]   = PSSC_SLEEP2_OFS;
	// dwell reset comes from the parameter so a bench can shorten the sleep
	assign cfg_rst[0]   = PSSC_AWAKE_RST;
	assign cfg_rst[1]   = {PSSC_SLEEP1_RST[31:21], DWELL_RESET, PSSC_SLEEP1_RST[15:0]};
	assign cfg_rst[2]   = {PSSC_SLEEP2_RST[31:21], DWELL_RESET, PSSC_SLEEP2_RST[15:0]};

	// axi write side
	logic         aw_held_reg;
	logic [7:0]   aw_addr_reg;
	logic         w_held_reg;
	logic [31:0]  w_data_reg;
	logic [3:0]   w_strb_reg;
	logic         wr_fire;
	logic [31:0]  strb_mask;
	logic         wr_hit;
	logic         sleep_go_reg;

	assign wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign strb_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	assign wr_hit    = (aw_addr_reg == PSSC_AWAKE_OFS) || (aw_addr_reg == PSSC_SLEEP1_OFS)
		|| (aw_addr_reg == PSSC_SLEEP2_OFS) || (aw_addr_reg == PSSC_STATUS_OFS)
		|| (aw_addr_reg == PSSC_CONTROL_OFS);

	// address and data are taken in either order and held until the write is done
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			aw_held_reg   <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_held_reg    <= 1'b0;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
			end
			else if (wr_fire)
				aw_held_reg <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_held_reg <= 1'b0;
			// ready drops after a take and stays low while a response waits, so one write at a time is held
			s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !wr_fire && !s_axi_bvalid;
			s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !wr_fire && !s_axi_bvalid;
		end
	end

	// write response, one cycle after both halves are held
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= PSSC_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? PSSC_RESP_OKAY : PSSC_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// set one cycle after release; the registers below load their dwell reset from it
	logic init_done_reg;

	// configuration registers, one per entry
	for (genvar gi = 0; gi < 3; gi++)
	begin : g_cfg
		logic [31:0] m;
		assign m = strb_mask & cfg_wmask[gi];
		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
				cfg_reg[gi] <= (gi == 0) ? PSSC_AWAKE_RST : ((gi == 1) ? PSSC_SLEEP1_RST : PSSC_SLEEP2_RST);
			else if (!init_done_reg)
				cfg_reg[gi] <= cfg_rst[gi];
			else if (wr_fire && aw_addr_reg == cfg_ofs[gi])
				cfg_reg[gi] <= (cfg_reg[gi] & ~m) | (w_data_reg & m);
		end
	end

	// the dwell parameter is loaded once after release, never under the reset itself
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			init_done_reg <= 1'b0;
		else
			init_done_reg <= 1'b1;
	end

	// software sleep request, a one-cycle pulse from a control write
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			sleep_go_reg <= 1'b0;
		else
			sleep_go_reg <= wr_fire && aw_addr_reg == PSSC_CONTROL_OFS
				&& w_strb_reg[0] && w_data_reg[PSSC_SLEEP_GO];
	end

	// wake pin: three flops, level accepted when the last two agree
	logic [2:0] wake_sync_reg;
	logic       wake_level_reg;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wake_sync_reg  <= 3'h0;
			wake_level_reg <= 1'b0;
		end
		else
		begin
			wake_sync_reg <= {wake_sync_reg[1:0], wake_request};
			if (wake_sync_reg[1] == wake_sync_reg[2])
				wake_level_reg <= wake_sync_reg[2];
		end
	end

	// sequencer
	pssc_state_e  state_reg;
	pssc_state_e  state_next;
	logic [31:0]  dwell_cnt_reg;
	logic [31:0]  dwell_last;
	logic         dwell_done;
	logic [31:0]  cfg_next;

	// last count of the stay: two to the power of the field, minus one
	always_comb
	begin
		dwell_last = 32'h0000_0000;
		if (state_reg == PSSC_ST_SLEEP1)
			dwell_last = (32'h0000_0001 << cfg_reg[1][PSSC_DWELL_MSB:PSSC_DWELL_LSB]) - 32'h0000_0001;
		else if (state_reg == PSSC_ST_SLEEP2)
			dwell_last = (32'h0000_0001 << cfg_reg[2][PSSC_DWELL_MSB:PSSC_DWELL_LSB]) - 32'h0000_0001;
	end
	assign dwell_done = (dwell_cnt_reg >= dwell_last);

	// next state; wait and waking states last one cycle here
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			PSSC_ST_RESET:  state_next = init_done_reg ? PSSC_ST_WAIT : PSSC_ST_RESET;
			PSSC_ST_ASLEEP: state_next = wake_level_reg ? PSSC_ST_WAKE1 : PSSC_ST_ASLEEP;
			PSSC_ST_WAKE1:  state_next = PSSC_ST_WAKE2;
			PSSC_ST_WAKE2:  state_next = PSSC_ST_WAIT;
			PSSC_ST_WAIT:   state_next = PSSC_ST_AWAKE;
			PSSC_ST_AWAKE:  state_next = sleep_go_reg ? PSSC_ST_SLEEP1 : PSSC_ST_AWAKE;
			PSSC_ST_SLEEP1: state_next = dwell_done ? PSSC_ST_SLEEP2 : PSSC_ST_SLEEP1;
			PSSC_ST_SLEEP2: state_next = dwell_done ? PSSC_ST_ASLEEP : PSSC_ST_SLEEP2;
			default:        state_next = PSSC_ST_RESET;
		endcase
	end

	// state and dwell counter; the counter restarts on every state change
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg     <= PSSC_ST_RESET;
			dwell_cnt_reg <= 32'h0000_0000;
		end
		else
		begin
			state_reg     <= state_next;
			dwell_cnt_reg <= (state_next != state_reg) ? 32'h0000_0000 : dwell_cnt_reg + 32'h0000_0001;
		end
	end

	// settings of the state about to be entered; the reset state keeps everything off
	always_comb
	begin
		cfg_next = 32'h0000_0000;
		unique case (state_next)
			PSSC_ST_RESET:  cfg_next = 32'h0000_0000;
			PSSC_ST_ASLEEP: cfg_next = PSSC_ASLEEP_CFG;
			PSSC_ST_WAKE1:  cfg_next = PSSC_WAKE1_CFG;
			PSSC_ST_WAKE2:  cfg_next = PSSC_WAKE2_CFG;
			PSSC_ST_WAIT:   cfg_next = PSSC_WAKE2_CFG;
			PSSC_ST_AWAKE:  cfg_next = cfg_reg[0];
			PSSC_ST_SLEEP1: cfg_next = cfg_reg[1];
			PSSC_ST_SLEEP2: cfg_next = cfg_reg[2];
			default:        cfg_next = 32'h0000_0000;
		endcase
	end

	// outputs follow the register live, so software changes land without a state change
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			supply_ctrl <= '0;
		else
		begin
			supply_ctrl.tile_clk_off            <= cfg_next[PSSC_TILE_OFF];
			supply_ctrl.analogue_pfm            <= cfg_next[PSSC_ANA_MODE];
			supply_ctrl.core_pfm                <= cfg_next[PSSC_CORE_MODE];
			supply_ctrl.io_supply_output_en     <= cfg_next[PSSC_IO_EN];
			supply_ctrl.pll_supply_regulator_en <= cfg_next[PSSC_PLL_EN];
			supply_ctrl.analogue_converter_en   <= cfg_next[PSSC_ANA_EN];
			supply_ctrl.core_converter_en       <= cfg_next[PSSC_CORE_EN];
		end
	end

	// three-bit state code
	logic [2:0] code_next;
	always_comb
	begin
		code_next = PSSC_CODE_RESET;
		unique case (state_next)
			PSSC_ST_RESET:  code_next = PSSC_CODE_RESET;
			PSSC_ST_ASLEEP: code_next = PSSC_CODE_ASLEEP;
			PSSC_ST_WAKE1:  code_next = PSSC_CODE_WAKE1;
			PSSC_ST_WAKE2:  code_next = PSSC_CODE_WAKE2;
			PSSC_ST_WAIT:   code_next = PSSC_CODE_WAIT;
			PSSC_ST_AWAKE:  code_next = PSSC_CODE_AWAKE;
			PSSC_ST_SLEEP1: code_next = PSSC_CODE_SLEEP1;
			PSSC_ST_SLEEP2: code_next = PSSC_CODE_SLEEP2;
			default:        code_next = PSSC_CODE_RESET;
		endcase
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state_code <= PSSC_CODE_RESET;
		else
			state_code <= code_next;
	end

	// read side; a new address is taken only once the previous answer has left
	logic [31:0] rd_word;
	logic        rd_hit;
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'h0})
			PSSC_AWAKE_OFS:   rd_word = cfg_reg[0];
			PSSC_SLEEP1_OFS:  rd_word = cfg_reg[1];
			PSSC_SLEEP2_OFS:  rd_word = cfg_reg[2];
			PSSC_STATUS_OFS:  rd_word = {13'h0000, state_code, 1'b0, supply_ctrl.tile_clk_off, 4'h0,
				supply_ctrl.analogue_pfm, supply_ctrl.core_pfm, 2'h0, supply_ctrl.io_supply_output_en,
				supply_ctrl.pll_supply_regulator_en, 2'h0, supply_ctrl.analogue_converter_en,
				supply_ctrl.core_converter_en};
			PSSC_CONTROL_OFS: rd_word = 32'h0000_0000;
			default:          rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= PSSC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_hit ? PSSC_RESP_OKAY : PSSC_RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
		end
	end

endmodule : pssc_top
`default_nettype wire

// >>> verif/pssc_top_sva.sv
// assertions on the ports of the power state sequencer
`timescale 1ns/1ps
`default_nettype none
module pssc_top_sva
	import pssc_pkg::*;
(
	input wire logic         clk,           // clock
	input wire logic         rst_b,         // reset, active low
	input wire logic         s_axi_awvalid, // aw valid
	input wire logic         s_axi_awready, // aw ready
	input wire logic         s_axi_wvalid,  // w valid
	input wire logic         s_axi_wready,  // w ready
	input wire logic [1:0]   s_axi_bresp,   // b resp
	input wire logic         s_axi_bvalid,  // b valid
	input wire logic         s_axi_bready,  // b ready
	input wire logic         s_axi_arvalid, // ar valid
	input wire logic         s_axi_arready, // ar ready
	input wire logic [31:0]  s_axi_rdata,   // r data
	input wire logic         s_axi_rvalid,  // r valid
	input wire logic         s_axi_rready,  // r ready
	input wire pssc_supply_s supply_ctrl,   // supply controls
	input wire logic [2:0]   state_code     // state code
);
	// one clock domain, so clocking and disable are shared
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// bus takes, the first step of each read and of each write taken on both channels at once
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	bresp_due_a: assert property (wr_take |-> ##[1:3] s_axi_bvalid) else $error("write response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_due_a: assert property (rd_take |-> ##[1:2] s_axi_rvalid) else $error("read data late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("address taken while busy");
	// analogue enable is fixed high in every configured state
	ana_fixed_a: assert property (state_code != PSSC_CODE_RESET |-> supply_ctrl.analogue_converter_en)
		else $error("analogue enable dropped");
	wait_awake_a: assert property (state_code == PSSC_CODE_WAIT |=> state_code == PSSC_CODE_AWAKE)
		else $error("wait not followed by awake");
	awake_exit_a: assert property ($changed(state_code) && $past(state_code) == PSSC_CODE_AWAKE |->
		state_code == PSSC_CODE_SLEEP1) else $error("awake left wrongly");
	sleep_next_a: assert property ($changed(state_code) && $past(state_code) == PSSC_CODE_SLEEP1 |->
		state_code == PSSC_CODE_SLEEP2) else $error("first sleep left wrongly");
	asleep_next_a: assert property ($changed(state_code) && $past(state_code) == PSSC_CODE_SLEEP2 |->
		state_code == PSSC_CODE_ASLEEP) else $error("second sleep left wrongly");
endmodule : pssc_top_sva
`default_nettype wire

// >>> verif/pssc_wake_model.sv
// model of the wake source at the sequencer's far side
`timescale 1ns/1ps
`default_nettype none
module pssc_wake_model
	import pssc_pkg::*;
(
	input wire logic       clk,          // clock
	input wire logic       rst_b,        // reset, active low
	input wire logic       wake_go,      // bench asks for a wake
	input wire logic [2:0] state_code,   // sequencer state
	output logic           wake_request  // wake level to the sequencer
);
	// held until waking is seen, since a short pulse may vanish in the synchroniser
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			wake_request <= 1'b0;
		else if (state_code == PSSC_CODE_WAKE1)
			wake_request <= 1'b0;
		else if (wake_go)
			wake_request <= 1'b1;
endmodule : pssc_wake_model
`default_nettype wire

// >>> verif/tb_pssc_top.sv
// self-checking bench for the power state sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_pssc_top;
	import pssc_pkg::*;
	localparam logic [4:0] DW = 5'h03;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic [1:0] b;} pssc_row_s;
	logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic wake_go, wake;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, got;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic [2:0] state_code;
	pssc_supply_s supply_ctrl;
	int failures, samples_checked, n;
	// writes, readback and supplies; bit 1 and reserved bits never move
	pssc_row_s rows [7] = '{
		'{8'h18, 32'hFFFF_FFFF, 32'h0000_4333, PSSC_RESP_OKAY},
		'{8'h18, 32'h0000_0000, 32'h0000_0002, PSSC_RESP_OKAY},
		'{8'h18, 32'h0000_0121, 32'h0000_0123, PSSC_RESP_OKAY},
		'{8'h1C, 32'hFFFF_FFFF, 32'h001F_4333, PSSC_RESP_OKAY},
		'{8'h1C, 32'h0002_4210, 32'h0002_4212, PSSC_RESP_OKAY},
		'{8'h20, 32'h0003_0301, 32'h0003_0303, PSSC_RESP_OKAY},
		'{8'h30, 32'h0000_0001, 32'h0000_0000, PSSC_RESP_SLVERR}};
	pssc_top #(.DWELL_RESET(DW)) dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wake_request(wake),
		.supply_ctrl(supply_ctrl), .state_code(state_code));
	pssc_wake_model wm (.clk(clk), .rst_b(rst_b), .wake_go(wake_go), .state_code(state_code), .wake_request(wake));
	// 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] sup(input logic [31:0] v);
		return {25'h0, v[14], v[9], v[8], v[5], v[4], v[1], v[0]};
	endfunction : sup
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	// each channel released at its own take; ready held until the answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	// counts settled cycles spent in one state
	task automatic stay(input logic [2:0] c, output int k);
		k = 0;
		while (state_code !== c)
		begin
			@(posedge clk);
			#1;
		end
		while (state_code === c)
		begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask : stay
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		test_done;
	end
	initial
	begin
		{rst_b, awvalid, wvalid, bready, arvalid, rready, wake_go} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d, rsp);
			check(rsp, rows[i].b);
			rd(rows[i].a, got, rsp);
			check(got, rows[i].r);
			check(rsp, rows[i].b);
			if (rows[i].a == PSSC_AWAKE_OFS) check({25'h0, supply_ctrl}, sup(rows[i].r));
		end
		// sleep walk: first sleep dwell 2, second dwell 3
		wr(PSSC_CONTROL_OFS, 32'h0000_0001, rsp);
		// the sequencer leaves awake at the edge where the response is taken
		#1;
		check(state_code, PSSC_CODE_SLEEP1);
		check({25'h0, supply_ctrl}, sup(32'h0002_4212));
		stay(PSSC_CODE_SLEEP1, n);
		check(n, 32'd4);
		check({25'h0, supply_ctrl}, sup(32'h0003_0303));
		stay(PSSC_CODE_SLEEP2, n);
		check(n, 32'd8);
		check(state_code, PSSC_CODE_ASLEEP);
		// a sleep request outside awake is lost
		wr(PSSC_CONTROL_OFS, 32'h0000_0001, rsp);
		repeat (4) @(posedge clk);
		#1;
		check(state_code, PSSC_CODE_ASLEEP);
		wake_go <= 1'b1;
		stay(PSSC_CODE_ASLEEP, n);
		wake_go <= 1'b0;
		stay(PSSC_CODE_WAIT, n);
		check(state_code, PSSC_CODE_AWAKE);
		check({25'h0, supply_ctrl}, sup(32'h0000_0123));
		// mid-run reset restores the reset values
		rst_b <= 1'b0;
		@(posedge clk);
		#1;
		check({state_code, supply_ctrl}, 10'h000);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		rd(PSSC_AWAKE_OFS, got, rsp);
		check(got, PSSC_AWAKE_RST);
		rd(PSSC_SLEEP1_OFS, got, rsp);
		check(got, {11'h0, DW, 16'h0022});
		rd(PSSC_SLEEP2_OFS, got, rsp);
		check(got, {11'h0, DW, 16'h0002});
		test_done;
	end
endmodule : tb_pssc_top
bind pssc_top pssc_top_sva chk (.clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .supply_ctrl(supply_ctrl), .state_code(state_code));
`default_nettype wire
